// ==== hdl/led_dev_end.sv ====
/*
  Device end: power-up sequencer, switching clock selection, sync loss
  handling, low power entry, sink gating and trim measurement.
  Assumes analog status inputs are asynchronous and get two flops.
*/
module led_dev_end #(
    parameter int unsigned LP_CYCLES = led_seq_pkg::LP_SW_CYC // low-power hold
) (
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    led_link_if.dev                          link,
    input  wire logic                        undervoltage_lockout_ok,
    input  wire logic                        ch_ready,
    input  wire logic [led_seq_pkg::CH_N-1:0] ch_short,
    input  wire logic [led_seq_pkg::CH_N-1:0] ch_unused,
    input  wire logic [led_seq_pkg::SW_PER_W-1:0] rset_period,
    output logic                             sw_tick,
    output logic                             sw_en,
    output logic                             gate_on,
    output logic [led_seq_pkg::CH_N-1:0]     sink_on,
    output logic [led_seq_pkg::CH_N-1:0]     loop_mask,
    output logic                             ss_current,
    output logic                             full_limit,
    output logic                             comp_float,
    output logic                             low_power,
    output logic                             sync_locked,
    output logic [7:0]                       trim_level
);
    import led_seq_pkg::*;

    typedef struct packed {
        pins_t                p1;        // first sync stage
        pins_t                p2;        // second sync stage
        logic                 syn_d;     // previous sync level
        logic                 sync_mode; // running from sync edges
        logic [7:0]           gap;       // cycles since last sync edge
        logic [SW_PER_W-1:0]  div;       // resistor clock divider
        seq_t                 st;        // sequencer state
        logic [11:0]          det;       // detect wait count
        logic [LP_W-1:0]      lp;        // enable-low count
        logic [CH_N-1:0]      used;      // qualified channels
        logic                 sw_tick;   // switching clock pulse
        logic                 sw_en;     // boost switching allowed
        logic                 gate_on;   // input disconnect closed
        logic [CH_N-1:0]      sink_on;   // sinks conducting
        logic [CH_N-1:0]      loop_mask; // headroom loop members
        logic                 ss_cur;    // soft-start sink current
        logic                 full_lim;  // full switch limit
        logic                 comp_float; // compensation floated
        logic                 lowpwr;    // low power mode
    } dev_t;

    dev_t r_r;  // state
    dev_t r_nxt; // next state

    // counter step that stops at a limit
    function automatic logic [7:0] inc_sat8(input logic [7:0] v, input logic [7:0] lim);
        inc_sat8 = (v >= lim) ? lim : v + 8'h01;
    endfunction : inc_sat8

    // clamp programmed period into the legal range
    function automatic logic [SW_PER_W-1:0] clamp_per(input logic [SW_PER_W-1:0] p);
        if (p < SW_PER_MIN) begin
            clamp_per = SW_PER_MIN;
        end else if (p > SW_PER_MAX) begin
            clamp_per = SW_PER_MAX;
        end else begin
            clamp_per = p;
        end
    endfunction : clamp_per

    logic                rise;     // sync rising edge
    logic                lost;     // no sync edge for the loss time
    logic                suspend;  // switching paused at changeover
    logic                low_long; // sync held low past loss time
    logic                tick;     // switching clock this cycle
    logic                on;       // sinks may conduct
    logic                run;      // soft start or regulation
    logic [SW_PER_W-1:0] per;      // effective period

    // all next-state logic
    always_comb begin
        r_nxt       = r_r;
        r_nxt.p1    = '{en: link.en_dim, syn: link.sync_level, undervoltage_lockout: undervoltage_lockout_ok, ready: ch_ready,
                        trim: link.trim_pwm, shrt: ch_short, unused: ch_unused};
        r_nxt.p2    = r_r.p1;
        r_nxt.syn_d = r_r.p2.syn;

        // sync edge watch
        rise      = r_r.p2.syn & ~r_r.syn_d;
        r_nxt.gap = (r_r.p2.syn != r_r.syn_d) ? 8'h00 : inc_sat8(r_r.gap, SYNC_LOSS_CYC);
        lost      = (r_r.gap == SYNC_LOSS_CYC);
        low_long  = lost & ~r_r.p2.syn;
        suspend   = r_r.sync_mode & (r_r.gap >= SYNC_GAP_CYC);
        if (rise) begin
            r_nxt.sync_mode = 1'b1;
        end else if (lost) begin
            r_nxt.sync_mode = 1'b0;
        end

        // switching clock: sync edges or resistor divider
        per  = clamp_per(rset_period);
        tick = 1'b0;
        if (r_r.sync_mode) begin
            tick      = rise;
            r_nxt.div = '0;
        end else if (r_r.div >= per - 1'b1) begin
            tick      = 1'b1;
            r_nxt.div = '0;
        end else begin
            r_nxt.div = r_r.div + 1'b1;
        end
        r_nxt.sw_tick = tick;

        // enable-low timer for low power
        if (r_r.p2.en) begin
            r_nxt.lp     = '0;
            r_nxt.lowpwr = 1'b0;
        end else if (tick && r_r.lp != LP_W'(LP_CYCLES)) begin
            r_nxt.lp = r_r.lp + 1'b1;
            if (r_nxt.lp == LP_W'(LP_CYCLES)) begin
                r_nxt.lowpwr = 1'b1;
            end
        end

        // sequencer
        case (r_r.st)
            SEQ_IDLE: begin
                // pin must float up or carry a clock
                if (r_r.p2.en && r_r.p2.undervoltage_lockout && (r_r.p2.syn || r_r.sync_mode)) begin
                    r_nxt.st  = SEQ_DETECT;
                    r_nxt.det = '0;
                end
            end
            SEQ_DETECT: begin
                if (r_r.det != DET_WAIT) begin
                    r_nxt.det = r_r.det + {11'h000, tick};
                end else if (~|r_r.p2.shrt) begin
                    r_nxt.used = ~r_r.p2.unused;
                    r_nxt.st   = SEQ_SOFT;
                end
            end
            SEQ_SOFT: begin
                // enough pin headroom: full current
                if (r_r.p2.ready) begin
                    r_nxt.st = SEQ_REG;
                end
            end
            SEQ_REG: begin
                r_nxt.st = SEQ_REG; // hold in regulation
            end
            SEQ_SHUT: begin
                if (r_r.p2.syn) begin
                    r_nxt.st = SEQ_SOFT;
                end
            end
            default: begin
                r_nxt.st = SEQ_IDLE; // stray code
            end
        endcase

        // shutdown overrides, lowest first
        if (low_long && r_r.st != SEQ_IDLE) begin
            r_nxt.st = SEQ_SHUT;
        end
        if (!r_r.p2.undervoltage_lockout || r_nxt.lowpwr) begin
            r_nxt.st   = SEQ_IDLE;
            r_nxt.used = '0;
        end

        // output decode from the next state
        run              = (r_nxt.st == SEQ_SOFT) || (r_nxt.st == SEQ_REG);
        on               = run & r_r.p2.en;
        r_nxt.gate_on    = run || (r_nxt.st == SEQ_DETECT);
        r_nxt.sw_en      = on & ~suspend;
        r_nxt.sink_on    = on ? r_nxt.used : '0;
        r_nxt.loop_mask  = run ? r_nxt.used : '0;
        r_nxt.comp_float = ~on;
        r_nxt.ss_cur     = (r_nxt.st == SEQ_SOFT);
        r_nxt.full_lim   = (r_nxt.st == SEQ_REG);
    end

    // state register, everything off after reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r_r          <= '0;
            r_r.st       <= SEQ_IDLE;
            // released sync pin idles high: no false rising edge after reset
            r_r.p1.syn   <= 1'b1;
            r_r.p2.syn   <= 1'b1;
            r_r.syn_d    <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // trim measurement on the synchronised trim input
    trim_duty_meter u_trim (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .trim_in (r_r.p2.trim),
        .level   (trim_level)
    );

    // outputs straight from the state register
    assign sw_tick     = r_r.sw_tick;
    assign sw_en       = r_r.sw_en;
    assign gate_on     = r_r.gate_on;
    assign sink_on     = r_r.sink_on;
    assign loop_mask   = r_r.loop_mask;
    assign ss_current  = r_r.ss_cur;
    assign full_limit  = r_r.full_lim;
    assign comp_float  = r_r.comp_float;
    assign low_power   = r_r.lowpwr;
    assign sync_locked = r_r.sync_mode;
endmodule : led_dev_end

// ==== hdl/led_seq_pkg.sv ====
/*
  Constants, types and timing counts shared by both ends of the LED
  backlight sequencer link. Assumes a single 20 MHz system clock (mclk).
*/
// What this block does
// - wait 3000-4000 switching cycles before channel judging
// - channel near unused level marked unused
// - unused channel dropped from regulation and headroom loop
// - shorted channel holds sequencer before soft start
// - soft start reduced currents, then full limits
// - resistor sets switching clock 580 kHz to 2.3 MHz
// - resistor switching clock clamped to 3.5 MHz maximum; sync edges pass unclamped
// - no power-up while sync pin held low
// - host sync pulses high and low at least 150 ns
// - sync lost: revert to resistor clock, pause under 7 us
// - sync low beyond 7 us shuts everything down
// - sync released after shutdown goes to soft start
// - enable low 32750 switching cycles enters low power
// - enable high sinks full current, low turns off
// - enable rise to sink current under 500 ns
// - trim duty reduces current inversely
// - host ties trim input low when unused
// - host applies trim no later than enable
package led_seq_pkg;
    localparam int unsigned MCLK_HZ      = 20_000_000; // system clock rate
    localparam int unsigned MCLK_MHZ     = 20;         // same, in MHz
    localparam int unsigned CH_N         = 4;          // sink channels
    localparam int unsigned SW_PER_W     = 6;          // divider period width
    localparam int unsigned SW_FMAX_HZ   = 3_500_000;  // fault clamp
    localparam int unsigned SW_FMIN_HZ   = 580_000;    // lowest programmed
    localparam int unsigned SW_FHI_HZ    = 2_300_000;  // highest programmed
    // least period rounds up, longest rounds down
    localparam logic [SW_PER_W-1:0] SW_PER_MIN = SW_PER_W'((MCLK_HZ + SW_FMAX_HZ - 1) / SW_FMAX_HZ);
    localparam logic [SW_PER_W-1:0] SW_PER_HI  = SW_PER_W'((MCLK_HZ + SW_FHI_HZ - 1) / SW_FHI_HZ);
    localparam logic [SW_PER_W-1:0] SW_PER_MAX = SW_PER_W'(MCLK_HZ / SW_FMIN_HZ);
    localparam int unsigned DET_MIN      = 3000;       // detect wait, low end
    localparam int unsigned DET_MAX      = 4000;       // detect wait, high end
    localparam logic [11:0] DET_WAIT     = 12'((DET_MIN + DET_MAX) / 2);
    localparam int unsigned SYNC_LOSS_NS = 7000;       // sync loss / held low
    localparam logic [7:0]  SYNC_LOSS_CYC = 8'(SYNC_LOSS_NS * MCLK_MHZ / 1000);
    localparam logic [7:0]  SYNC_GAP_CYC = 8'(SW_PER_MAX) + 8'h01; // no edge: pause
    localparam int unsigned SYNC_MIN_NS  = 150;        // least sync half
    localparam int unsigned SYNC_MIN_CYC = (SYNC_MIN_NS * MCLK_MHZ + 999) / 1000;
    localparam int unsigned EN_DELAY_NS  = 500;        // longest enable delay
    localparam int unsigned EN_DELAY_CYC = EN_DELAY_NS * MCLK_MHZ / 1000;
    localparam int unsigned LP_SW_CYC    = 32_750;     // low-power hold
    localparam int unsigned LP_W         = 15;         // low-power counter
    // product needs 64 bits before the divide
    localparam int unsigned LP_HOLD_MCLK = 32'(64'(LP_SW_CYC) * MCLK_HZ / SW_FMIN_HZ + 1);
    localparam int unsigned TRIM_WIN_W   = 12;         // duty window width
    localparam logic [TRIM_WIN_W:0] TRIM_WIN = 13'h1000; // window, mclk cycles
    localparam int unsigned TRIM_SHIFT   = 4;          // window to 8-bit level
    localparam logic [7:0]  TRIM_FULL    = 8'hff;      // full current level

    // sequencer states, gray along the power-up path
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'h0,
        SEQ_DETECT = 3'h1,
        SEQ_SOFT   = 3'h3,
        SEQ_REG    = 3'h2,
        SEQ_SHUT   = 3'h6
    } seq_t;

    // host control of the frequency-set / sync pin
    typedef enum logic [1:0] {
        SYNC_RELEASE = 2'h0,
        SYNC_LOW     = 2'h1,
        SYNC_CLOCK   = 2'h2
    } sync_sel_t;

    // asynchronous device inputs, synchronised as one bundle
    typedef struct packed {
        logic            en;
        logic            syn;
        logic            undervoltage_lockout;
        logic            ready;
        logic            trim;
        logic [CH_N-1:0] shrt;
        logic [CH_N-1:0] unused;
    } pins_t;
endpackage : led_seq_pkg

// ==== hdl/led_link_if.sv ====
/*
  Link between host controller and LED driver: enable/dim, the
  frequency-set/sync pin and the trim PWM input. Assumes the sync pin
  floats high through the set resistor when nobody drives it.
*/
interface led_link_if;
    logic en_dim;     // enable / dim level
    logic sync_drv;   // host drive value of sync pin
    logic sync_oe;    // host drives sync pin
    logic trim_pwm;   // current trim pwm
    logic sync_level; // resolved pin level

    // released pin rises to the resistor bias, read as high
    assign sync_level = sync_oe ? sync_drv : 1'b1;

    modport dev  (input en_dim, input sync_level, input trim_pwm);
    modport host (output en_dim, output sync_drv, output sync_oe, output trim_pwm);
endinterface : led_link_if

// ==== hdl/trim_duty_meter.sv ====
/*
  Measures the low share of the trim pwm over a fixed window and turns
  it into a current level. Assumes its input is already synchronised.
*/
module trim_duty_meter (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       trim_in,
    output logic [7:0]      level
);
    import led_seq_pkg::*;

    typedef struct packed {
        logic [TRIM_WIN_W-1:0] win;   // window position
        logic [TRIM_WIN_W:0]   low;   // low cycles in window
        logic [7:0]            level; // published level
    } meter_t;

    meter_t r_r;  // state
    meter_t r_nxt; // next state

    // count low cycles, publish at window end
    always_comb begin
        r_nxt     = r_r;
        r_nxt.win = r_r.win + 1'b1;
        r_nxt.low = r_r.low + {{TRIM_WIN_W{1'b0}}, ~trim_in};
        if (&r_r.win) begin
            // higher duty gives lower current; tied low gives full
            if (r_nxt.low >= TRIM_WIN) begin
                r_nxt.level = TRIM_FULL;
            end else begin
                r_nxt.level = 8'(r_nxt.low >> TRIM_SHIFT);
            end
            r_nxt.low = '0;
        end
    end

    // register, full current after reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r_r <= '{win: '0, low: '0, level: TRIM_FULL};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign level = r_r.level;
endmodule : trim_duty_meter

// ==== hdl/led_host_end.sv ====
/*
  Host end: drives enable/dim, the sync pin and the trim pwm.
  Assumes user requests come from logic on mclk.
*/
module led_host_end #(
    parameter int unsigned LP_HOLD   = led_seq_pkg::LP_HOLD_MCLK, // sleep hold, mclk
    parameter int unsigned SYNC_HALF = 5                          // sync half period
) (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    led_link_if.host                    link,
    input  wire logic                   en_req,
    input  wire logic                   sleep_req,
    input  wire led_seq_pkg::sync_sel_t sync_sel,
    input  wire logic [7:0]             trim_duty,
    output logic                        sleep_done
);
    import led_seq_pkg::*;

    // never shorter than the least sync half period
    localparam int unsigned HALF_EFF = (SYNC_HALF < SYNC_MIN_CYC) ? SYNC_MIN_CYC : SYNC_HALF;
    localparam logic [7:0]  HALF_END = 8'(HALF_EFF - 1);
    localparam logic [20:0] HOLD_END = 21'(LP_HOLD);

    typedef struct packed {
        logic [7:0]  tcnt;    // trim period position
        logic        trim_ok; // trim has started
        logic        trim;    // trim pin
        logic        en;      // enable pin
        logic [7:0]  scnt;    // sync half counter
        logic        sdrv;    // sync drive value
        logic        soe;     // sync drive enable
        logic [20:0] lp;      // sleep hold count
        logic        done;    // sleep reached
    } host_t;

    host_t r_r;  // state
    host_t r_nxt; // next state

    // all next-state logic
    always_comb begin
        r_nxt      = r_r;
        r_nxt.tcnt = r_r.tcnt + 8'h01;
        // zero duty keeps the pin grounded
        r_nxt.trim = (trim_duty != 8'h00) && (r_r.tcnt < trim_duty);
        // enable follows trim start, never before it
        r_nxt.trim_ok = en_req & (r_r.trim_ok | (r_r.tcnt == 8'h00));
        r_nxt.en      = r_nxt.trim_ok & ~sleep_req;

        // sleep: hold enable low long enough
        if (!sleep_req) begin
            r_nxt.lp   = '0;
            r_nxt.done = 1'b0;
        end else if (r_r.lp != HOLD_END) begin
            r_nxt.lp = r_r.lp + 21'h000001;
        end else begin
            r_nxt.done = 1'b1;
        end

        // sync pin drive
        case (sync_sel)
            SYNC_LOW: begin
                r_nxt.soe  = 1'b1;
                r_nxt.sdrv = 1'b0;
                r_nxt.scnt = '0;
            end
            SYNC_CLOCK: begin
                r_nxt.soe = 1'b1;
                if (r_r.scnt >= HALF_END) begin
                    r_nxt.scnt = '0;
                    r_nxt.sdrv = ~r_r.sdrv;
                end else begin
                    r_nxt.scnt = r_r.scnt + 8'h01;
                end
            end
            default: begin
                r_nxt.soe  = 1'b0; // released, floats up
                r_nxt.sdrv = 1'b0;
                r_nxt.scnt = '0;
            end
        endcase
    end

    // state register, pins idle after reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from flops
    assign link.en_dim   = r_r.en;
    assign link.sync_drv = r_r.sdrv;
    assign link.sync_oe  = r_r.soe;
    assign link.trim_pwm = r_r.trim;
    assign sleep_done    = r_r.done;
endmodule : led_host_end

// ==== testbench/led_link_sva.sv ====
/*
  Assertions on the host/device link and on the device status outputs.
  Assumes one mclk domain and rst_n synchronous, active low.
*/
module led_link_sva #(
    parameter int unsigned LP_CYCLES = 32750 // low-power hold, ticks
) (
    input wire logic                          mclk,
    input wire logic                          rst_n,
    input wire logic                          en_dim,
    input wire logic                          sync_level,
    input wire logic                          sw_tick,
    input wire logic                          sw_en,
    input wire logic                          gate_on,
    input wire logic [led_seq_pkg::CH_N-1:0]  sink_on,
    input wire logic [led_seq_pkg::CH_N-1:0]  loop_mask,
    input wire logic [led_seq_pkg::CH_N-1:0]  ch_unused,
    input wire logic                          ss_current,
    input wire logic                          full_limit,
    input wire logic                          comp_float,
    input wire logic                          low_power
);
    timeunit 1ns;
    timeprecision 1ns;
    import led_seq_pkg::*;
    logic [15:0] low_r;   // sync pin low run
    logic [15:0] low_nxt;
    logic [15:0] enl_r;   // enable low run
    logic [15:0] enl_nxt;

    // saturating run counters
    always_comb begin
        low_nxt = (sync_level || &low_r) ? (sync_level ? 16'h0 : low_r) : low_r + 16'h1;
        enl_nxt = (en_dim || &enl_r) ? (en_dim ? 16'h0 : enl_r) : enl_r + 16'h1;
    end

    // register the counters
    always_ff @(posedge mclk) begin
        low_r <= rst_n ? low_nxt : 16'h0;
        enl_r <= rst_n ? enl_nxt : 16'h0;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_sink_needs_en: assert property (sink_on != '0 |-> $past(en_dim, 3))
        else $error("sinks on without enable");
    a_sink_off_low: assert property ((!en_dim)[*4] |-> sink_on == '0)
        else $error("sinks on while enable low");
    a_comp_float_off: assert property (comp_float |-> sink_on == '0 && !sw_en)
        else $error("comp floated while running");
    a_unused_out: assert property (((loop_mask | sink_on) & ch_unused) == '0)
        else $error("unused channel in use");
    a_soft_limits: assert property (ss_current |-> !full_limit)
        else $error("soft current with full limit");
    a_gate_first: assert property (!gate_on |-> sink_on == '0 && !sw_en)
        else $error("running with disconnect open");
    a_sync_shut: assert property (low_r > 16'd150 |-> !gate_on && !sw_en && sink_on == '0)
        else $error("no shutdown on held-low sync");
    a_power_up_sync: assert property ($rose(gate_on) |-> low_r < 16'd10)
        else $error("power-up with sync pin low");
    a_tick_space: assert property (sw_tick |=> (!sw_tick)[*5])
        else $error("switching faster than clamp");
    a_lp_hold: assert property ($rose(low_power) |-> enl_r >= LP_CYCLES * SW_PER_MIN)
        else $error("low power entered too early");
    a_lp_off: assert property (low_power |-> sink_on == '0 && !gate_on)
        else $error("running in low power");
    a_sync_hi_min: assert property ($rose(sync_level) |=> sync_level[*2])
        else $error("sync high time short");
    a_sync_lo_min: assert property ($fell(sync_level) |=> (!sync_level)[*2])
        else $error("sync low time short");
endmodule : led_link_sva

// ==== testbench/led_driver_sequencer_sync_dim_test.sv ====
/*
  Bench joining host end and device end over the link interface.
  Assumes both ends run on mclk; inputs change at the falling edge.
*/
module led_driver_sequencer_sync_dim_test;
    timeunit 1ns;
    timeprecision 1ns;
    import led_seq_pkg::*;
    localparam int unsigned LP  = 100; // short low-power hold, ticks
    localparam int          PER = 9;   // resistor period, mclk cycles
    logic            mclk = 1'b0;
    logic            rst_n = 1'b0;
    logic            undervoltage_lockout_ok, ch_ready, en_req, sleep_req, sleep_done;
    logic [CH_N-1:0] ch_short, ch_unused, sink_on, loop_mask;
    sync_sel_t       sync_sel;
    logic [7:0]      trim_duty, trim_level;
    logic            sw_tick, sw_en, gate_on, ss_current, full_limit;
    logic            comp_float, low_power, sync_locked, en_dim, trim_pwm;
    int              err_count = 0;
    int              n_checks = 0;
    int              c, g;

    always #25 mclk = ~mclk;

    led_link_if i_led_link_if ();
    assign en_dim   = i_led_link_if.en_dim;
    assign trim_pwm = i_led_link_if.trim_pwm;

    led_host_end #(.LP_HOLD(1200), .SYNC_HALF(5)) i_led_host_end (.mclk(mclk), .rst_n(rst_n),
        .link(i_led_link_if), .en_req(en_req), .sleep_req(sleep_req), .sync_sel(sync_sel),
        .trim_duty(trim_duty), .sleep_done(sleep_done));
    led_dev_end #(.LP_CYCLES(LP)) i_led_dev_end (.mclk(mclk), .rst_n(rst_n), .link(i_led_link_if),
        .undervoltage_lockout_ok(undervoltage_lockout_ok), .ch_ready(ch_ready), .ch_short(ch_short), .ch_unused(ch_unused),
        .rset_period(SW_PER_W'(PER)), .sw_tick(sw_tick), .sw_en(sw_en), .gate_on(gate_on),
        .sink_on(sink_on), .loop_mask(loop_mask), .ss_current(ss_current), .full_limit(full_limit),
        .comp_float(comp_float), .low_power(low_power), .sync_locked(sync_locked),
        .trim_level(trim_level));
    led_link_sva #(.LP_CYCLES(LP)) i_led_link_sva (.mclk(mclk), .rst_n(rst_n), .en_dim(en_dim),
        .sync_level(i_led_link_if.sync_level), .sw_tick(sw_tick), .sw_en(sw_en), .gate_on(gate_on),
        .sink_on(sink_on), .loop_mask(loop_mask), .ch_unused(ch_unused), .ss_current(ss_current),
        .full_limit(full_limit), .comp_float(comp_float), .low_power(low_power));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // wait whole cycles, landing on a falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    // cycles between two switching ticks
    task automatic tick_gap(output int gap);
        for (int i = 0; i < 100 && sw_tick !== 1'b1; i++) cyc(1);
        cyc(1);
        for (gap = 1; gap < 100 && sw_tick !== 1'b1; gap++) cyc(1);
    endtask : tick_gap

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    // hang guard, about 95k cycles
    initial begin
        #4_750_000;
        err_count++;
        close_out();
    end

    // main sequence
    initial begin
        undervoltage_lockout_ok   = 1'b1;
        ch_ready  = 1'b0;
        en_req    = 1'b1;
        sleep_req = 1'b0;
        ch_short  = 4'h2;
        ch_unused = 4'h8;
        sync_sel  = SYNC_LOW;
        trim_duty = 8'h00;
        cyc(6);
        rst_n = 1'b1;
        cyc(400);
        chk(gate_on, 1'b0);
        chk({trim_pwm, trim_level}, 9'h0ff);
        sync_sel = SYNC_RELEASE;
        for (c = 0; c < 100 && gate_on !== 1'b1; c++) cyc(1);
        chk(c < 100, 1'b1);
        // short held past the whole detect wait: soft start must not begin
        cyc(34000);
        chk(ss_current, 1'b0);
        ch_short = 4'h0;
        for (g = 0; g < 20 && ss_current !== 1'b1; g++) cyc(1);
        chk(g < 20, 1'b1);
        chk({full_limit, sink_on}, 5'h07);
        ch_ready = 1'b1;
        cyc(10);
        chk({full_limit, ss_current, loop_mask}, 6'h27);
        tick_gap(g);
        chk(g, PER);
        // dim cycle with trim set first
        trim_duty = 8'h40;
        en_req = 1'b0;
        for (c = 0; c < 300 && en_dim !== 1'b0; c++) cyc(1);
        cyc(4);
        chk({sink_on, comp_float, sw_en}, 6'h02);
        en_req = 1'b1;
        for (c = 0; c < 300 && en_dim !== 1'b1; c++) cyc(1);
        chk(trim_pwm, 1'b1);
        for (c = 0; c < 20 && sink_on !== 4'h7; c++) cyc(1);
        chk(c, 3);
        chk(low_power, 1'b0);
        // trim duty to current level
        for (int k = 0; k < 2; k++) begin
            trim_duty = k ? 8'h80 : 8'h40;
            cyc(9000);
            chk(trim_level, k ? 8'h80 : 8'hc0);
        end
        // external sync, then its loss
        sync_sel = SYNC_CLOCK;
        cyc(200);
        chk(sync_locked, 1'b1);
        tick_gap(g);
        chk(g, 10);
        sync_sel = SYNC_RELEASE;
        for (c = 0; c < 300 && sync_locked !== 1'b0; c++) cyc(1);
        cyc(20);
        chk({c <= 150, sync_locked, sw_en}, 3'h5);
        tick_gap(g);
        chk(g, PER);
        // held low: shutdown, release goes to soft start
        sync_sel = SYNC_LOW;
        cyc(200);
        chk({gate_on, sw_en, sink_on}, 6'h00);
        sync_sel = SYNC_RELEASE;
        for (c = 0; c < 500 && full_limit !== 1'b1; c++) cyc(1);
        chk(c < 500, 1'b1);
        // low-power entry and wake
        sleep_req = 1'b1;
        cyc(800);
        chk(low_power, 1'b0);
        for (c = 0; c < 800 && sleep_done !== 1'b1; c++) cyc(1);
        chk({low_power, gate_on}, 2'h2);
        sleep_req = 1'b0;
        cyc(300);
        chk(low_power, 1'b0);
        // wake runs a clean detect wait, timed from the end of sleep
        for (g = 300; g < 40000 && ss_current !== 1'b1; g++) cyc(1);
        chk(g >= 3000 * PER && g <= 4000 * PER, 1'b1);
        // second reset mid-run
        rst_n = 1'b0;
        cyc(6);
        chk({gate_on, sink_on, low_power, trim_level}, 14'h00ff);
        rst_n = 1'b1;
        cyc(2);
        close_out();
    end
endmodule : led_driver_sequencer_sync_dim_test
